// >>> verilog/rps_pkg.sv
// shared constants and types for the remappable pin select block
package rps_pkg;
	localparam int SEL_W = 5;
	localparam int NUM_PINS = 26;
	localparam int NUM_IN = 14;
	localparam int NUM_OUT = 7;
	localparam int CTL_W = 8;
	localparam int CFG_W = 8;
	localparam int LOCK_BIT = 6;
	localparam int ONE_WAY_BIT = 5;
	localparam logic [CTL_W-1:0] KEY_FIRST = 8'h46;
	localparam logic [CTL_W-1:0] KEY_SECOND = 8'h57;
	localparam logic [SEL_W-1:0] IN_SEL_RST = 5'h1F;
	localparam logic [SEL_W-1:0] IN_SEL_GND = 5'h1F;
	localparam logic [SEL_W-1:0] OUT_SEL_RST = 5'h00;
	localparam logic [SEL_W-1:0] OUT_SEL_NULL = 5'h00;
	localparam logic LOCK_RST = 1'b0;
	// peripheral input order
	localparam int PIN_EXT_INT_ONE = 0;
	localparam int PIN_EXT_INT_TWO = 1;
	localparam int PIN_TIMER2_CLK = 2;
	localparam int PIN_TIMER3_CLK = 3;
	localparam int PIN_CAPTURE_ONE = 4;
	localparam int PIN_CAPTURE_TWO = 5;
	localparam int PIN_CAPTURE_SEVEN = 6;
	localparam int PIN_CAPTURE_EIGHT = 7;
	localparam int PIN_COMPARE_FAULT_A = 8;
	localparam int PIN_UART1_RX = 9;
	localparam int PIN_UART1_CTS = 10;
	localparam int PIN_SPI1_DATA_IN = 11;
	localparam int PIN_SPI1_CLOCK_IN = 12;
	localparam int PIN_SPI1_SELECT_IN = 13;
	// peripheral output codes, index = peripheral output port bit
	localparam logic [SEL_W-1:0] OSEL_UART1_TX = 5'h03;
	localparam logic [SEL_W-1:0] OSEL_UART1_RTS = 5'h04;
	localparam logic [SEL_W-1:0] OSEL_SPI1_DATA_OUT = 5'h07;
	localparam logic [SEL_W-1:0] OSEL_SPI1_CLOCK_OUT = 5'h08;
	localparam logic [SEL_W-1:0] OSEL_SPI1_SELECT_OUT = 5'h09;
	localparam logic [SEL_W-1:0] OSEL_COMPARE_ONE = 5'h12;
	localparam logic [SEL_W-1:0] OSEL_COMPARE_TWO = 5'h13;
	localparam logic [NUM_OUT-1:0][SEL_W-1:0] OSEL_CODES = {
		OSEL_COMPARE_TWO, OSEL_COMPARE_ONE, OSEL_SPI1_SELECT_OUT,
		OSEL_SPI1_CLOCK_OUT, OSEL_SPI1_DATA_OUT, OSEL_UART1_RTS,
		OSEL_UART1_TX};
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_KEY1,
		SEQ_ARMED
	} rps_seq_e;
endpackage

// >>> verilog/rps_out_mux.sv
// output selector for one remappable pin
`timescale 1ns/100ps
module rps_out_mux
	import rps_pkg::*;
#(
	parameter int PER_N = NUM_OUT
) (
	input wire logic [SEL_W-1:0] sel,
	input wire logic [PER_N-1:0] per_out,
	input wire logic [PER_N-1:0] per_oe,
	input wire logic port_out,
	input wire logic port_oe,
	output logic mux_out,
	output logic mux_oe
);
	logic [PER_N-1:0] hit;
	logic any_hit;

	genvar k;
	generate
		for (k = 0; k < PER_N; k++) begin : g_hit
			assign hit[k] = (sel == OSEL_CODES[k]);
		end
	endgenerate

	// null and unused codes fall back to port logic
	assign any_hit = |hit;
	assign mux_out = any_hit ? |(hit & per_out) : port_out;
	assign mux_oe = any_hit ? |(hit & per_oe) : port_oe;
endmodule

// >>> verilog/rps_top.sv
// remappable pin select: selectors, write lock, shadow monitor
// Functional notes
// - each peripheral input has a 5-bit selector; value n picks pin n
// - up to 26 remappable pins; selectors beyond present pins ignored
// - each pin has a 5-bit output selector choosing a peripheral
// - output code zero leaves pin to its ordinary port logic
// - codes 03 uart tx, 04 uart rts, 07 spi data out
// - codes 08 spi clock, 09 spi select, 12 compare1, 13 compare2
// - fourteen peripheral inputs are remappable
// - input and output maps are set independently
// - while locked, map writes complete but change nothing
// - lock is bit 6 of the oscillator control register
// - lock changes only after writes 46 then 57 then one write
// - lock holds its state until explicitly changed again
// - shadow copies compared always; mismatch raises reset request
// - with one-way bit set, lock cannot clear once set
// - one-way bit default set gives one session; cleared unlimited
// - input selectors reset to 11111, which ties input to ground
`timescale 1ns/100ps
module rps_top
	import rps_pkg::*;
#(
	parameter int N_PINS = NUM_PINS,
	parameter int N_IN = NUM_IN,
	parameter int N_OUT = NUM_OUT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic osc_ctl_wr,
	input wire logic [CTL_W-1:0] osc_ctl_wdata,
	input wire logic [CFG_W-1:0] osc_config_word,
	input wire logic map_wr,
	input wire logic map_is_out,
	input wire logic [SEL_W-1:0] map_idx,
	input wire logic [SEL_W-1:0] map_wdata,
	input wire logic [N_PINS-1:0] pin_in,
	input wire logic [N_PINS-1:0] port_out,
	input wire logic [N_PINS-1:0] port_oe,
	input wire logic [N_OUT-1:0] periph_out,
	input wire logic [N_OUT-1:0] periph_oe,
	output logic [N_PINS-1:0] pin_out,
	output logic [N_PINS-1:0] pin_oe,
	output logic [N_IN-1:0] periph_in,
	output logic map_write_lock,
	output logic cfg_mismatch_rst,
	output logic [N_IN*SEL_W-1:0] input_map_register,
	output logic [N_PINS*SEL_W-1:0] output_map_register
);
	rps_seq_e seq_r;
	rps_seq_e seq_nxt;
	logic lock_r;
	logic lock_nxt;
	logic lock_once_r;
	logic mismatch_r;
	logic [N_IN-1:0][SEL_W-1:0] in_sel_r;
	logic [N_IN-1:0][SEL_W-1:0] in_shadow_r;
	logic [N_PINS-1:0][SEL_W-1:0] out_sel_r;
	logic [N_PINS-1:0][SEL_W-1:0] out_shadow_r;
	logic [N_PINS-1:0] mux_out;
	logic [N_PINS-1:0] mux_oe;
	logic [N_IN-1:0] in_pick;
	logic [N_PINS-1:0] pin_out_r;
	logic [N_PINS-1:0] pin_oe_r;
	logic [N_IN-1:0] periph_in_r;

	wire one_way = osc_config_word[ONE_WAY_BIT];
	wire key1_hit = osc_ctl_wr && (osc_ctl_wdata == KEY_FIRST);
	wire key2_hit = osc_ctl_wr && (osc_ctl_wdata == KEY_SECOND);
	wire lock_wr = osc_ctl_wr && (seq_r == SEQ_ARMED);
	wire lock_req = osc_ctl_wdata[LOCK_BIT];
	wire clear_blocked = one_way && (lock_r || lock_once_r) && !lock_req;
	wire map_ok = map_wr && !lock_r;
	wire in_idx_ok = (32'(map_idx) < N_IN);
	wire out_idx_ok = (32'(map_idx) < N_PINS);
	wire in_wr = map_ok && !map_is_out && in_idx_ok;
	wire out_wr = map_ok && map_is_out && out_idx_ok;
	wire shadow_diff = (in_sel_r != in_shadow_r) ||
		(out_sel_r != out_shadow_r);

	// key sequence: any other write breaks it
	always_comb begin
		case (seq_r)
			SEQ_IDLE: seq_nxt = key1_hit ? SEQ_KEY1 : SEQ_IDLE;
			SEQ_KEY1: begin
				if (key2_hit)
					seq_nxt = SEQ_ARMED;
				else if (key1_hit)
					seq_nxt = SEQ_KEY1;
				else if (osc_ctl_wr || map_wr)
					seq_nxt = SEQ_IDLE;
				else
					seq_nxt = SEQ_KEY1;
			end
			SEQ_ARMED: begin
				if (osc_ctl_wr || map_wr)
					seq_nxt = SEQ_IDLE;
				else
					seq_nxt = SEQ_ARMED;
			end
			default: seq_nxt = SEQ_IDLE;
		endcase
	end

	// lock holds unless a single armed write changes it
	assign lock_nxt = (lock_wr && !clear_blocked) ? lock_req : lock_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seq_r <= SEQ_IDLE;
			lock_r <= LOCK_RST;
			lock_once_r <= 1'b0;
		end else begin
			seq_r <= seq_nxt;
			lock_r <= lock_nxt;
			if (lock_r)
				lock_once_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			in_sel_r <= {N_IN{IN_SEL_RST}};
			in_shadow_r <= {N_IN{IN_SEL_RST}};
		end else if (in_wr) begin
			in_sel_r[map_idx] <= map_wdata;
			in_shadow_r[map_idx] <= map_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_sel_r <= {N_PINS{OUT_SEL_RST}};
			out_shadow_r <= {N_PINS{OUT_SEL_RST}};
		end else if (out_wr) begin
			out_sel_r[map_idx] <= map_wdata;
			out_shadow_r[map_idx] <= map_wdata;
		end
	end

	genvar i;
	generate
		for (i = 0; i < N_IN; i++) begin : g_in
			// ground for 11111 and for pins not present
			assign in_pick[i] = (32'(in_sel_r[i]) < N_PINS) ?
				pin_in[in_sel_r[i]] : 1'b0;
		end
		for (i = 0; i < N_PINS; i++) begin : g_out
			rps_out_mux #(
				.PER_N(N_OUT)
			) u_mux (
				.sel(out_sel_r[i]),
				.per_out(periph_out),
				.per_oe(periph_oe),
				.port_out(port_out[i]),
				.port_oe(port_oe[i]),
				.mux_out(mux_out[i]),
				.mux_oe(mux_oe[i])
			);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_out_r <= '0;
			pin_oe_r <= '0;
			periph_in_r <= '0;
			mismatch_r <= 1'b0;
		end else begin
			pin_out_r <= mux_out;
			pin_oe_r <= mux_oe;
			periph_in_r <= in_pick;
			mismatch_r <= shadow_diff;
		end
	end

	assign pin_out = pin_out_r;
	assign pin_oe = pin_oe_r;
	assign periph_in = periph_in_r;
	assign map_write_lock = lock_r;
	assign cfg_mismatch_rst = mismatch_r;
	assign input_map_register = in_sel_r;
	assign output_map_register = out_sel_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_keys;
		(key1_hit && seq_r != SEQ_ARMED) ##1 key2_hit;
	endsequence
	sequence s_armed_write;
		s_keys ##1 (osc_ctl_wr && !clear_blocked);
	endsequence

	property p_locked_write_ignored;
		(lock_r && map_wr) |=> ($stable(in_sel_r) && $stable(out_sel_r));
	endproperty
	a_locked_write_ignored: assert property (p_locked_write_ignored)
		else $error("map changed while locked");

	property p_unlocked_write;
		out_wr |=> (out_sel_r[$past(map_idx)] == $past(map_wdata));
	endproperty
	a_unlocked_write: assert property (p_unlocked_write)
		else $error("output map write lost");

	property p_in_write;
		in_wr |=> (in_sel_r[$past(map_idx)] == $past(map_wdata));
	endproperty
	a_in_write: assert property (p_in_write)
		else $error("input map write lost");

	property p_null_port;
		(out_sel_r[0] == OUT_SEL_NULL) |=>
			(pin_out[0] == $past(port_out[0]) &&
			pin_oe[0] == $past(port_oe[0]));
	endproperty
	a_null_port: assert property (p_null_port)
		else $error("null code did not give port logic");

	property p_uart_tx;
		(out_sel_r[0] == OSEL_UART1_TX) |=>
			(pin_out[0] == $past(periph_out[0]) &&
			pin_oe[0] == $past(periph_oe[0]));
	endproperty
	a_uart_tx: assert property (p_uart_tx)
		else $error("uart tx not routed");

	property p_compare_two;
		(out_sel_r[0] == OSEL_COMPARE_TWO) |=>
			(pin_out[0] == $past(periph_out[6]));
	endproperty
	a_compare_two: assert property (p_compare_two)
		else $error("compare two not routed");

	property p_in_ground;
		(in_sel_r[0] == IN_SEL_GND) |=> (periph_in[0] == 1'b0);
	endproperty
	a_in_ground: assert property (p_in_ground)
		else $error("grounded input not low");

	property p_in_route;
		(32'(in_sel_r[0]) < N_PINS) |=>
			(periph_in[0] == $past(pin_in[in_sel_r[0]]));
	endproperty
	a_in_route: assert property (p_in_route)
		else $error("input not routed from selected pin");

	property p_seq_change;
		s_armed_write |=> (lock_r == $past(osc_ctl_wdata[LOCK_BIT]));
	endproperty
	a_seq_change: assert property (p_seq_change)
		else $error("armed write did not set lock");

	property p_no_seq_no_change;
		$past(seq_r) != SEQ_ARMED |-> $stable(lock_r);
	endproperty
	a_no_seq_no_change: assert property (p_no_seq_no_change)
		else $error("lock changed without key sequence");

	property p_one_way;
		(one_way && lock_r) |=> lock_r;
	endproperty
	a_one_way: assert property (p_one_way)
		else $error("one-way lock cleared");

	property p_mismatch;
		shadow_diff |=> cfg_mismatch_rst;
	endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("shadow mismatch not reported");

	property p_no_mismatch;
		!shadow_diff |=> !cfg_mismatch_rst;
	endproperty
	a_no_mismatch: assert property (p_no_mismatch)
		else $error("mismatch reported without cause");
endmodule

// >>> verification/rps_far_model.sv
// far side model: remappable peripherals and external pin drivers
`timescale 1ns/100ps
module rps_far_model
	import rps_pkg::*;
(
	input wire logic clk,
	input wire logic [NUM_OUT-1:0] want_out,
	input wire logic [NUM_OUT-1:0] want_oe,
	input wire logic [NUM_PINS-1:0] want_pin,
	output logic [NUM_OUT-1:0] periph_out = '0,
	output logic [NUM_OUT-1:0] periph_oe = '0,
	output logic [NUM_PINS-1:0] pin_in = '0
);
	// peripherals launch data and enable together on the clock
	always @(posedge clk) begin
		periph_out <= want_out;
		periph_oe <= want_oe;
		pin_in <= want_pin;
	end
endmodule

// >>> verification/rps_top_tb.sv
// self-checking bench for the remappable pin select block
`timescale 1ns/100ps
module rps_top_tb
	import rps_pkg::*;
;
	localparam int W = NUM_PINS * SEL_W;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic osc_ctl_wr = 1'b0;
	logic map_wr = 1'b0;
	logic map_is_out = 1'b0;
	logic [CTL_W-1:0] wdata = 8'h00;
	logic [CFG_W-1:0] cfg = 8'h20;
	logic [SEL_W-1:0] idx = 5'h00;
	logic [SEL_W-1:0] sel = 5'h00;
	logic [SEL_W-1:0] c;
	logic [NUM_PINS-1:0] pins = '0, p_out = '0, p_oe = '0;
	logic [NUM_OUT-1:0] w_out = '0, w_oe = '0, periph_out, periph_oe;
	logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe;
	logic [NUM_IN-1:0] periph_in;
	logic lock, mism;
	logic [NUM_IN*SEL_W-1:0] in_map, snap_i;
	logic [W-1:0] out_map, snap_o;
	int n_fail = 0;
	int checks = 0;
	integer seed = 34719;
	int i, p, k;

	initial forever #5 clk = ~clk;

	rps_far_model u_far (.clk(clk), .want_out(w_out), .want_oe(w_oe),
		.want_pin(pins), .periph_out(periph_out), .periph_oe(periph_oe),
		.pin_in(pin_in));

	rps_top u_dut (.clk(clk), .rst_n(rst_n), .osc_ctl_wr(osc_ctl_wr),
		.osc_ctl_wdata(wdata), .osc_config_word(cfg), .map_wr(map_wr),
		.map_is_out(map_is_out), .map_idx(idx), .map_wdata(sel),
		.pin_in(pin_in), .port_out(p_out), .port_oe(p_oe),
		.periph_out(periph_out), .periph_oe(periph_oe), .pin_out(pin_out),
		.pin_oe(pin_oe), .periph_in(periph_in), .map_write_lock(lock),
		.cfg_mismatch_rst(mism), .input_map_register(in_map),
		.output_map_register(out_map));

	task automatic chk(input logic [W-1:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// expected pin data and enable for one output routing step
	function automatic logic [W-1:0] exp_pin(input int code_i,
		input int pin_i);
		if (code_i < NUM_OUT)
			return W'({w_out[code_i], w_oe[code_i]});
		return W'({p_out[pin_i], p_oe[pin_i]});
	endfunction

	task automatic wrap_up();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic osc(input logic [CTL_W-1:0] d);
		@(posedge clk);
		osc_ctl_wr <= 1'b1;
		wdata <= d;
		@(posedge clk);
		osc_ctl_wr <= 1'b0;
	endtask

	task automatic mapw(input logic o, input logic [SEL_W-1:0] a, v);
		@(posedge clk);
		map_wr <= 1'b1;
		map_is_out <= o;
		idx <= a;
		sel <= v;
		@(posedge clk);
		map_wr <= 1'b0;
	endtask

	// keys and lock write on back-to-back cycles
	task automatic lock_seq(input logic v);
		@(posedge clk);
		osc_ctl_wr <= 1'b1;
		wdata <= KEY_FIRST;
		@(posedge clk);
		wdata <= KEY_SECOND;
		@(posedge clk);
		wdata <= CTL_W'(v) << LOCK_BIT;
		@(posedge clk);
		osc_ctl_wr <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic do_rst(input logic [CFG_W-1:0] cf);
		cfg <= cf;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	initial begin
		#400000;
		n_fail++;
		wrap_up();
	end

	initial begin
		do_rst(8'h20);
		chk(W'(in_map), W'({NUM_IN{IN_SEL_RST}}));
		chk(out_map, W'(0));
		chk(W'(lock), W'(LOCK_RST));
		$display("test reset done");
		for (k = 0; k < 24; k++) begin
			i = $unsigned($random(seed)) % NUM_IN;
			p = (k == 0) ? NUM_PINS - 1 : $unsigned($random(seed)) % NUM_PINS;
			mapw(1'b0, SEL_W'(i), SEL_W'(p));
			p_oe <= '0;
			pins <= NUM_PINS'($random(seed));
			repeat (3) @(posedge clk);
			chk(W'(in_map[i*SEL_W +: SEL_W]), W'(p));
			chk(W'(periph_in[i]), W'(pins[p]));
		end
		for (k = 0; k < 2; k++) begin
			mapw(1'b0, SEL_W'(k), k ? IN_SEL_GND : 5'h1A);
			pins <= '1;
			repeat (3) @(posedge clk);
			chk(W'(periph_in[k]), W'(0));
		end
		$display("test input map done");
		for (k = 0; k < NUM_OUT + 2; k++) begin
			p = $unsigned($random(seed)) % NUM_PINS;
			// pin 0 carries the routing assertions
			if (k == 0 || k == NUM_OUT - 1)
				p = 0;
			c = k < NUM_OUT ? OSEL_CODES[k] : SEL_W'(k - NUM_OUT);
			mapw(1'b1, SEL_W'(p), c);
			w_out <= NUM_OUT'($random(seed));
			w_oe <= NUM_OUT'($random(seed));
			p_out <= NUM_PINS'($random(seed));
			p_oe <= NUM_PINS'($random(seed));
			repeat (3) @(posedge clk);
			chk(W'(out_map[p*SEL_W +: SEL_W]), W'(c));
			chk(W'({pin_out[p], pin_oe[p]}), exp_pin(k, p));
		end
		$display("test output map done");
		lock_seq(1'b1);
		chk(W'(lock), W'(1));
		snap_i = in_map;
		snap_o = out_map;
		mapw(1'b1, 5'h00, OSEL_UART1_TX);
		mapw(1'b0, 5'h00, 5'h02);
		@(posedge clk);
		chk(out_map, snap_o);
		chk(W'(in_map), W'(snap_i));
		lock_seq(1'b0);
		chk(W'(lock), W'(1));
		$display("test one way lock done");
		do_rst(8'h00);
		lock_seq(1'b1);
		lock_seq(1'b0);
		chk(W'(lock), W'(0));
		mapw(1'b0, 5'h00, 5'h05);
		mapw(1'b0, 5'h01, 5'h06);
		@(posedge clk);
		chk(W'(in_map[9:0]), W'(10'h0C5));
		osc(KEY_SECOND);
		osc(8'h40);
		osc(KEY_FIRST);
		mapw(1'b0, 5'h02, 5'h07);
		osc(KEY_SECOND);
		osc(8'h40);
		repeat (2) @(posedge clk);
		chk(W'(lock), W'(0));
		chk(W'(mism), W'(0));
		osc(KEY_FIRST);
		osc(KEY_SECOND);
		osc(8'h40);
		repeat (2) @(posedge clk);
		chk(W'(lock), W'(1));
		mapw(1'b0, 5'h00, 5'h0A);
		@(posedge clk);
		chk(W'(in_map[4:0]), W'(5'h05));
		$display("test lock sequence done");
		wrap_up();
	end
endmodule
